// ==== rtl/fec_defs.vh ====
// Register map, field positions, reset values and timing counts of the parity repair block.
// Functional notes
// RULE1: Serialize each source packet as P, X, CC, M, PT, timestamp, length, then body.
// RULE2: Length element is the big-endian byte count beyond the 12-byte RTP header.
// RULE3: Shorter source strings are padded with zero bytes to the longest one.
// RULE4: Repair carries a 16-byte FEC header; its string XORs all protected strings.
// RULE5: First seven string bits go to repair P, X, CC and M.
// RULE6: Next 7 bits fill payload_type_rebuild_field, next 32 timestamp_rebuild_field.
// RULE7: Next 16 bits fill length recovery; remaining bits form the repair payload.
// RULE8: lowest_seq_base holds the lowest protected sequence number, wrap-aware.
// RULE9: Sender sets header-extension flag to 1 and type field to 0.
// RULE10: Mask, N, D, index, seq_base_extension are sent zero and ignored on receive.
// RULE11: Offset field carries the column count, row_total_field the row count.
// RULE12: Repair protects base plus i times columns modulo 65536, i below rows.
// RULE13: Rebuild only with the repair present and exactly one source missing.
// RULE14: Repair string uses recovery PT and timestamp; CSRC, extension, padding empty.
// RULE15: Received source strings shorter than the repair string get zero bytes.
// RULE16: Recovered string is XOR of received source strings and the repair string.
// RULE17: Rebuilt packet starts as a bare 12-byte RTP header with version 2.
// RULE18: Load P, X, CC, M and PT of the rebuilt header from the recovered string.
// RULE19: Rebuilt sequence is missing_seq_number; timestamp is the next 32 bits.
// RULE20: Next 16 bits give a byte count; append that many recovered bytes.
// RULE21: Rebuilt synchronization source is copied from the protected source stream.
// RULE22: Any method is allowed if rebuilt packets match the reference bit for bit.
// RULE23: Column and row counts are each between 1 and 255.
// RULE24: Decoder should not hold a set longer than the repair window in microseconds.
// RULE25: Repair RTP sequence, timestamp, identifier and PT follow repair flow conventions.
`ifndef FEC_DEFS_VH
`define FEC_DEFS_VH

`define FEC_REG_CTRL 8'h00
`define FEC_REG_GEOM 8'h04
`define FEC_REG_BASE 8'h08
`define FEC_REG_RHDR 8'h0C
`define FEC_REG_RTS 8'h10
`define FEC_REG_RSSRC 8'h14
`define FEC_REG_WIN 8'h18
`define FEC_REG_STAT 8'h1C
`define FEC_REG_MISS 8'h20

`define FEC_CTRL_MODE 0
`define FEC_CTRL_START 1
`define FEC_STAT_REP 3
`define FEC_STAT_REC 4
`define FEC_STAT_FAIL 5
`define FEC_STAT_FMT 6
`define FEC_STAT_GEOM 7

`define FEC_GEOM_RST 16'h0101
`define FEC_WIN_RST 32'h0000_03E8
`define FEC_RPT_RST 7'h60

`define FEC_RTP_HDR 16'h000C
`define FEC_REP_HDR 16'h001C
`define FEC_BUF_BYTES 16'h0040
`define FEC_RTP_VER 2'h2
`define FEC_HDR_EXT 1'h1
`define FEC_RESP_OK 2'h0
`define FEC_RESP_SLVERR 2'h2

`define FEC_US_NS 1000
`define FEC_CLK_NS 4
`define FEC_CYC_PER_US (`FEC_US_NS / `FEC_CLK_NS)

`endif

// ==== rtl/fec_parity_core.v ====
// Interleaved parity repair encoder and single-loss decoder with an AXI4-Lite register slave.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "fec_defs.vh"

module fec_parity_core (
	input wire CLK_SYS_I,
	input wire RST_N_I,
	input wire [7:0] AWADDR_I,
	input wire AWVALID_I,
	output wire AWREADY_O,
	input wire [31:0] WDATA_I,
	input wire [3:0] WSTRB_I,
	input wire WVALID_I,
	output wire WREADY_O,
	output reg [1:0] BRESP_O,
	output reg BVALID_O,
	input wire BREADY_I,
	input wire [7:0] ARADDR_I,
	input wire ARVALID_I,
	output wire ARREADY_O,
	output reg [31:0] RDATA_O,
	output reg [1:0] RRESP_O,
	output reg RVALID_O,
	input wire RREADY_I,
	input wire [7:0] SRC_DATA_I,
	input wire SRC_VALID_I,
	input wire SRC_LAST_I,
	output wire SRC_READY_O,
	input wire [7:0] REP_DATA_I,
	input wire REP_VALID_I,
	input wire REP_LAST_I,
	output wire REP_READY_O,
	output reg [7:0] OUT_DATA_O,
	output reg OUT_VALID_O,
	output reg OUT_LAST_O,
	output reg OUT_KIND_O,
	input wire OUT_READY_I
);

localparam ST_IDLE = 3'h0;
localparam ST_RUN = 3'h1;
localparam ST_CHK = 3'h2;
localparam ST_SKIP = 3'h3;
localparam ST_OUT = 3'h4;
localparam ST_DONE = 3'h5;

function [31:0] wmerge;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0] strb;
	integer k;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			wmerge[k*8 +: 8] = strb[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
		end
	end
endfunction

// Sequence a is earlier than b when the 16-bit difference is negative.
function seq_lt;
	input [15:0] a;
	input [15:0] b;
	reg [15:0] d;
	begin
		d = a - b;
		seq_lt = d[15];
	end
endfunction

// ----------------------------------------------------------------------
// Register slave
// ----------------------------------------------------------------------
reg aw_have_q, w_have_q;
reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
reg mode_q;
reg [7:0] geom_l_q, geom_d_q;
reg [15:0] base_q, rep_seq_q;
reg [6:0] rep_pt_q;
reg [31:0] rep_ts_q, rep_ssrc_q, win_q;
reg [31:0] rd_data;
reg rd_ok;
wire wr_do = aw_have_q && w_have_q && !BVALID_O;
wire [31:0] wr_ctrl = wmerge(32'h0000_0000, w_data_q, w_strb_q);
wire [31:0] geom_w = wmerge({16'h0000, geom_d_q, geom_l_q}, w_data_q, w_strb_q);
wire [31:0] base_w = wmerge({16'h0000, base_q}, w_data_q, w_strb_q);
wire [31:0] rhdr_w = wmerge({rep_seq_q, 9'h000, rep_pt_q}, w_data_q, w_strb_q);
wire start_w = wr_do && (aw_addr_q == `FEC_REG_CTRL) && wr_ctrl[`FEC_CTRL_START];
assign AWREADY_O = !aw_have_q && !BVALID_O;
assign WREADY_O = !w_have_q && !BVALID_O;
assign ARREADY_O = !RVALID_O;

always @(posedge CLK_SYS_I or negedge RST_N_I) begin
	if (!RST_N_I) begin
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		aw_addr_q <= 8'h00;
		w_data_q <= 32'h0000_0000;
		w_strb_q <= 4'h0;
		BVALID_O <= 1'b0;
		BRESP_O <= `FEC_RESP_OK;
		RVALID_O <= 1'b0;
		RRESP_O <= `FEC_RESP_OK;
		RDATA_O <= 32'h0000_0000;
		mode_q <= 1'b0;
		{geom_d_q, geom_l_q} <= `FEC_GEOM_RST;
		base_q <= 16'h0000;
		rep_seq_q <= 16'h0000;
		rep_pt_q <= `FEC_RPT_RST;
		rep_ts_q <= 32'h0000_0000;
		rep_ssrc_q <= 32'h0000_0000;
		win_q <= `FEC_WIN_RST;
	end else begin
		if (AWVALID_I && AWREADY_O) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= AWADDR_I;
		end
		if (WVALID_I && WREADY_O) begin
			w_have_q <= 1'b1;
			w_data_q <= WDATA_I;
			w_strb_q <= WSTRB_I;
		end
		if (wr_do) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			BVALID_O <= 1'b1;
			BRESP_O <= `FEC_RESP_OK;
			case (aw_addr_q)
			`FEC_REG_CTRL: if (w_strb_q[0]) mode_q <= w_data_q[`FEC_CTRL_MODE];
			`FEC_REG_GEOM: {geom_d_q, geom_l_q} <= geom_w[15:0];
			`FEC_REG_BASE: base_q <= base_w[15:0];
			`FEC_REG_RHDR: begin
				rep_seq_q <= rhdr_w[31:16];
				rep_pt_q <= rhdr_w[6:0];
			end
			`FEC_REG_RTS: rep_ts_q <= wmerge(rep_ts_q, w_data_q, w_strb_q);
			`FEC_REG_RSSRC: rep_ssrc_q <= wmerge(rep_ssrc_q, w_data_q, w_strb_q);
			`FEC_REG_WIN: win_q <= wmerge(win_q, w_data_q, w_strb_q);
			`FEC_REG_STAT, `FEC_REG_MISS: BRESP_O <= `FEC_RESP_OK;
			default: BRESP_O <= `FEC_RESP_SLVERR;
			endcase
		end else if (BVALID_O && BREADY_I) begin
			BVALID_O <= 1'b0;
		end
		if (ARVALID_I && ARREADY_O) begin
			RVALID_O <= 1'b1;
			RDATA_O <= rd_data;
			RRESP_O <= rd_ok ? `FEC_RESP_OK : `FEC_RESP_SLVERR;
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------------
// Packet engine state
// ----------------------------------------------------------------------
reg [2:0] st_q;
reg [15:0] idx_q, seq_q, lenrec_q, max_len_q, sum_q, low_q, miss_q, chk_acc_q, oidx_q, otot_q, rep_sent_q;
reg [7:0] b0_q, b1_q, cnt_q, chk_i_q;
reg [31:0] ts_q, ssrc_q, div_q, us_q;
reg [61:0] hdr_q;
reg [7:0] buf_q [0:63];
reg own_rep_q, rep_have_q, have_low_q, rec_q, fail_q, fmt_q, geom_err_q;
reg [7:0] ob;

wire at_start = (idx_q == 16'h0000);
wire rep_pick = mode_q && REP_VALID_I;
wire rep_now = at_start ? rep_pick : own_rep_q;
wire [7:0] din = rep_now ? REP_DATA_I : SRC_DATA_I;
wire dlast = rep_now ? REP_LAST_I : SRC_LAST_I;
wire [15:0] off = rep_now ? `FEC_REP_HDR : `FEC_RTP_HDR;
wire [15:0] pos = idx_q - off;
wire [15:0] len_w = idx_q + 16'h0001 - off;
wire [15:0] diff = seq_q - base_q;
wire [15:0] tri_w = (geom_d_q * (geom_d_q - 8'h01)) >> 1;
wire [15:0] miss_i = tri_w - sum_q;
wire [15:0] miss_seq = base_q + miss_i * {8'h00, geom_l_q};
wire fin_enc = !mode_q && (cnt_q == geom_d_q);
wire fin_rec = mode_q && rep_have_q && (cnt_q == geom_d_q - 8'h01);
wire fin_full = mode_q && (cnt_q == geom_d_q);
wire tmo = mode_q && (us_q >= win_q);
wire stop = (st_q == ST_RUN) && at_start && (fin_enc || fin_rec || fin_full || tmo);
wire flowing = ((st_q == ST_RUN) && !stop) || (st_q == ST_SKIP);
assign REP_READY_O = flowing && (at_start ? rep_pick : own_rep_q);
assign SRC_READY_O = flowing && (at_start ? !rep_pick : !own_rep_q);
wire take = (REP_READY_O && REP_VALID_I) || (SRC_READY_O && SRC_VALID_I);
wire buf_we = take && (st_q == ST_RUN) && (idx_q >= off) && (pos < `FEC_BUF_BYTES);
wire geom_ok = (geom_l_q != 8'h00) && (geom_d_q != 8'h00);
wire [15:0] rseq = rep_seq_q + rep_sent_q;

// Zero-extended XOR of every string into one buffer pads shorter strings for free.
always @(posedge CLK_SYS_I or negedge RST_N_I) begin : buf_proc
	integer k;
	if (!RST_N_I) begin
		for (k = 0; k < 64; k = k + 1) begin
			buf_q[k] <= 8'h00;
		end
	end else if (start_w) begin
		for (k = 0; k < 64; k = k + 1) begin
			buf_q[k] <= 8'h00;
		end
	end else if (buf_we) begin
		buf_q[pos[5:0]] <= buf_q[pos[5:0]] ^ din; // RULE3 RULE15 RULE16
	end
end

// ----------------------------------------------------------------------
// Outgoing packet bytes
// ----------------------------------------------------------------------
always @* begin : ob_proc
	reg [15:0] bp;
	bp = oidx_q - (OUT_KIND_O ? `FEC_RTP_HDR : `FEC_REP_HDR);
	ob = (bp < `FEC_BUF_BYTES) ? buf_q[bp[5:0]] : 8'h00;
	if (!OUT_KIND_O) begin
		case (oidx_q)
		16'h0000: ob = {`FEC_RTP_VER, hdr_q[61:56]}; // RULE5
		16'h0001: ob = {hdr_q[55], rep_pt_q}; // RULE5 RULE25
		16'h0002: ob = rseq[15:8]; // RULE25
		16'h0003: ob = rseq[7:0];
		16'h0004: ob = rep_ts_q[31:24];
		16'h0005: ob = rep_ts_q[23:16];
		16'h0006: ob = rep_ts_q[15:8];
		16'h0007: ob = rep_ts_q[7:0];
		16'h0008: ob = rep_ssrc_q[31:24];
		16'h0009: ob = rep_ssrc_q[23:16];
		16'h000A: ob = rep_ssrc_q[15:8];
		16'h000B: ob = rep_ssrc_q[7:0];
		16'h000C: ob = low_q[15:8]; // RULE8
		16'h000D: ob = low_q[7:0];
		16'h000E: ob = hdr_q[15:8]; // RULE7
		16'h000F: ob = hdr_q[7:0];
		16'h0010: ob = {`FEC_HDR_EXT, hdr_q[54:48]}; // RULE6 RULE9
		16'h0014: ob = hdr_q[47:40]; // RULE6
		16'h0015: ob = hdr_q[39:32];
		16'h0016: ob = hdr_q[31:24];
		16'h0017: ob = hdr_q[23:16];
		16'h0019: ob = geom_l_q; // RULE11
		16'h001A: ob = geom_d_q; // RULE11
		16'h0011, 16'h0012, 16'h0013, 16'h0018, 16'h001B: ob = 8'h00; // RULE4 RULE9 RULE10
		default: ob = ob; // RULE7
		endcase
	end else begin
		case (oidx_q)
		16'h0000: ob = {`FEC_RTP_VER, hdr_q[61:56]}; // RULE17 RULE18
		16'h0001: ob = hdr_q[55:48]; // RULE18
		16'h0002: ob = miss_q[15:8]; // RULE19
		16'h0003: ob = miss_q[7:0];
		16'h0004: ob = hdr_q[47:40]; // RULE19
		16'h0005: ob = hdr_q[39:32];
		16'h0006: ob = hdr_q[31:24];
		16'h0007: ob = hdr_q[23:16];
		16'h0008: ob = ssrc_q[31:24]; // RULE21
		16'h0009: ob = ssrc_q[23:16];
		16'h000A: ob = ssrc_q[15:8];
		16'h000B: ob = ssrc_q[7:0];
		default: ob = ob; // RULE20
		endcase
	end
end

// ----------------------------------------------------------------------
// Packet engine
// ----------------------------------------------------------------------
always @(posedge CLK_SYS_I or negedge RST_N_I) begin
	if (!RST_N_I) begin
		st_q <= ST_IDLE;
		{idx_q, seq_q, lenrec_q, max_len_q, sum_q, low_q, miss_q} <= 112'h0;
		{chk_acc_q, oidx_q, otot_q, rep_sent_q} <= 64'h0;
		{b0_q, b1_q, cnt_q, chk_i_q} <= 32'h0;
		{ts_q, ssrc_q, div_q, us_q} <= 128'h0;
		hdr_q <= 62'h0;
		{own_rep_q, rep_have_q, have_low_q, rec_q, fail_q, fmt_q, geom_err_q} <= 7'h00;
		{OUT_DATA_O, OUT_VALID_O, OUT_LAST_O, OUT_KIND_O} <= 11'h000;
	end else if (start_w) begin
		{idx_q, max_len_q, sum_q, cnt_q, div_q, us_q, hdr_q} <= 182'h0;
		{rep_have_q, have_low_q, rec_q, fail_q, fmt_q, own_rep_q} <= 6'h00;
		{OUT_VALID_O, OUT_LAST_O} <= 2'h0;
		geom_err_q <= !geom_ok; // RULE23
		st_q <= geom_ok ? ST_RUN : ST_IDLE; // RULE23
	end else begin
		// Repair window, counted in microseconds while the set is open.
		if (mode_q && (st_q == ST_RUN || st_q == ST_CHK || st_q == ST_SKIP)) begin
			if (div_q == `FEC_CYC_PER_US - 1) begin
				div_q <= 32'h0000_0000;
				us_q <= us_q + 32'h0000_0001; // RULE24
			end else begin
				div_q <= div_q + 32'h0000_0001;
			end
		end
		case (st_q)
		ST_RUN, ST_SKIP: begin
			if (stop) begin
				if (fin_enc) begin
					st_q <= ST_OUT;
					OUT_KIND_O <= 1'b0;
					otot_q <= `FEC_REP_HDR + max_len_q; // RULE4 RULE7
					oidx_q <= 16'h0000;
				end else if (fin_rec) begin
					st_q <= ST_OUT; // RULE13
					OUT_KIND_O <= 1'b1;
					miss_q <= miss_seq; // RULE12 RULE19
					otot_q <= `FEC_RTP_HDR + hdr_q[15:0]; // RULE20
					oidx_q <= 16'h0000;
				end else begin
					st_q <= ST_DONE;
					fail_q <= !fin_full; // RULE13 RULE24
				end
			end else if (take) begin
				idx_q <= idx_q + 16'h0001;
				if (at_start) own_rep_q <= rep_now;
				if (st_q == ST_RUN) begin
					if (!rep_now) begin
						case (idx_q)
						16'h0000: b0_q <= din;
						16'h0001: b1_q <= din;
						16'h0002, 16'h0003: seq_q <= {seq_q[7:0], din};
						16'h0004, 16'h0005, 16'h0006, 16'h0007: ts_q <= {ts_q[23:0], din};
						16'h0008, 16'h0009, 16'h000A, 16'h000B: ssrc_q <= {ssrc_q[23:0], din}; // RULE21
						default: ;
						endcase
						if ((idx_q == 16'h0003) && !dlast) begin
							st_q <= ST_CHK;
							chk_i_q <= 8'h00;
							chk_acc_q <= 16'h0000;
						end
					end else begin
						case (idx_q)
						16'h0000: b0_q <= din;
						16'h0001: b1_q <= din; // RULE14
						16'h000C, 16'h000D: seq_q <= {seq_q[7:0], din};
						16'h000E, 16'h000F: lenrec_q <= {lenrec_q[7:0], din};
						16'h0010: b1_q <= {b1_q[7], din[6:0]}; // RULE14
						16'h0014, 16'h0015, 16'h0016, 16'h0017: ts_q <= {ts_q[23:0], din}; // RULE14
						default: ;
						endcase
						// Only one repair per set, and only the one whose base matches.
						if ((idx_q == 16'h000D) && !dlast && (rep_have_q || ({seq_q[7:0], din} != base_q))) begin
							st_q <= ST_SKIP; // RULE10 RULE12
						end
					end
				end
				if (dlast) begin
					idx_q <= 16'h0000;
					st_q <= ST_RUN;
					if ((st_q == ST_RUN) && (idx_q + 16'h0001 >= off)) begin
						if (len_w > max_len_q) max_len_q <= len_w; // RULE3 RULE15
						if (rep_now) begin
							hdr_q <= hdr_q ^ {b0_q[5:0], b1_q, ts_q, lenrec_q}; // RULE14 RULE16
							rep_have_q <= 1'b1;
						end else begin
							hdr_q <= hdr_q ^ {b0_q[5:0], b1_q, ts_q, len_w}; // RULE1 RULE2 RULE4
							cnt_q <= cnt_q + 8'h01;
							sum_q <= sum_q + {8'h00, chk_i_q};
							if (!have_low_q || seq_lt(seq_q, low_q)) begin
								low_q <= seq_q; // RULE8
							end
							have_low_q <= 1'b1;
						end
					end else if (st_q == ST_RUN) begin
						fmt_q <= 1'b1;
					end
				end
				if (buf_we == 1'b0 && (st_q == ST_RUN) && (pos >= `FEC_BUF_BYTES) && (idx_q >= off)) begin
					fmt_q <= 1'b1;
				end
			end
		end
		ST_CHK: begin
			if (chk_acc_q == diff) begin
				st_q <= ST_RUN; // RULE12
			end else if (chk_i_q == geom_d_q - 8'h01) begin
				st_q <= ST_SKIP;
			end else begin
				chk_i_q <= chk_i_q + 8'h01;
				chk_acc_q <= chk_acc_q + {8'h00, geom_l_q}; // RULE12
			end
		end
		ST_OUT: begin
			if (!OUT_VALID_O || OUT_READY_I) begin
				if (oidx_q != otot_q) begin
					OUT_VALID_O <= 1'b1;
					OUT_DATA_O <= ob; // RULE22
					OUT_LAST_O <= (oidx_q == otot_q - 16'h0001);
					oidx_q <= oidx_q + 16'h0001;
				end else begin
					OUT_VALID_O <= 1'b0;
					OUT_LAST_O <= 1'b0;
					st_q <= ST_DONE;
					if (OUT_KIND_O) rec_q <= 1'b1;
					else rep_sent_q <= rep_sent_q + 16'h0001; // RULE25
				end
			end
		end
		default: ;
		endcase
	end
end

always @* begin
	rd_ok = 1'b1;
	case (ARADDR_I)
	`FEC_REG_CTRL: rd_data = {31'h0000_0000, mode_q};
	`FEC_REG_GEOM: rd_data = {16'h0000, geom_d_q, geom_l_q};
	`FEC_REG_BASE: rd_data = {16'h0000, base_q};
	`FEC_REG_RHDR: rd_data = {rep_seq_q, 9'h000, rep_pt_q};
	`FEC_REG_RTS: rd_data = rep_ts_q;
	`FEC_REG_RSSRC: rd_data = rep_ssrc_q;
	`FEC_REG_WIN: rd_data = win_q;
	`FEC_REG_STAT: rd_data = {16'h0000, cnt_q, geom_err_q, fmt_q, fail_q, rec_q, rep_have_q, st_q};
	`FEC_REG_MISS: rd_data = {low_q, miss_q};
	default: begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b0;
	end
	endcase
end

endmodule

// ==== sim/fec_out_sink.sv ====
// Downstream packet receiver that stalls the output stream in a fixed pattern.
`timescale 1ns/1ps

module fec_out_sink (
	input wire clk_i,
	input wire rst_n_i,
	output logic out_ready_o
);
	logic [2:0] ph_q;
	// Ready drops two cycles in five, so every packet sees a held byte.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ph_q <= 3'h0;
			out_ready_o <= 1'b0;
		end else begin
			ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
			out_ready_o <= (ph_q < 3'h3);
		end
	end
endmodule

// ==== sim/fec_parity_props.sv ====
// Checker for the output framing and intake check of the parity repair block.
`timescale 1ns/1ps

module fec_parity_props (
	input wire CLK_SYS_I,
	input wire RST_N_I,
	input wire SRC_VALID_I,
	input wire SRC_LAST_I,
	input wire SRC_READY_O,
	input wire [7:0] OUT_DATA_O,
	input wire OUT_VALID_O,
	input wire OUT_LAST_O,
	input wire OUT_KIND_O,
	input wire OUT_READY_I
);
	// ----------------------------------------
	// Byte position counters
	// ----------------------------------------
	logic [15:0] oi_q;
	logic [15:0] si_q;
	wire rep_b = OUT_VALID_O && !OUT_KIND_O;
	wire reb_b = OUT_VALID_O && OUT_KIND_O;
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			oi_q <= 16'h0000;
			si_q <= 16'h0000;
		end else begin
			if (OUT_VALID_O && OUT_READY_I)
				oi_q <= OUT_LAST_O ? 16'h0000 : oi_q + 16'h0001;
			if (SRC_VALID_I && SRC_READY_O)
				si_q <= SRC_LAST_I ? 16'h0000 : si_q + 16'h0001;
		end
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_rep_ver;
		rep_b && oi_q == 16'h0000 |-> OUT_DATA_O[7:6] == 2'h2;
	endproperty
	a_rep_ver: assert property (p_rep_ver) else $error("repair version wrong");
	property p_reb_ver;
		reb_b && oi_q == 16'h0000 |-> OUT_DATA_O[7:6] == 2'h2;
	endproperty
	a_reb_ver: assert property (p_reb_ver) else $error("rebuilt version wrong");
	property p_ext_flag;
		rep_b && oi_q == 16'h0010 |-> OUT_DATA_O[7];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("extension flag clear");
	property p_zero_fields;
		rep_b && (oi_q inside {16'h0011, 16'h0012, 16'h0013, 16'h0018, 16'h001B}) |-> OUT_DATA_O == 8'h00;
	endproperty
	a_zero_fields: assert property (p_zero_fields) else $error("reserved field set");
	property p_geom_fields;
		rep_b && (oi_q == 16'h0019 || oi_q == 16'h001A) |-> OUT_DATA_O != 8'h00;
	endproperty
	a_geom_fields: assert property (p_geom_fields) else $error("geometry field zero");
	property p_rep_len;
		rep_b && OUT_LAST_O |-> oi_q >= 16'h001B;
	endproperty
	a_rep_len: assert property (p_rep_len) else $error("repair too short");
	property p_hold;
		OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O) && $stable({OUT_LAST_O, OUT_KIND_O});
	endproperty
	a_hold: assert property (p_hold) else $error("output byte not held");
	property p_member_check;
		SRC_VALID_I && SRC_READY_O && si_q == 16'h0003 |=> !SRC_READY_O;
	endproperty
	a_member_check: assert property (p_member_check) else $error("no membership pause");
endmodule

bind fec_parity_core fec_parity_props fec_parity_props_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
	.SRC_VALID_I(SRC_VALID_I), .SRC_LAST_I(SRC_LAST_I), .SRC_READY_O(SRC_READY_O), .OUT_DATA_O(OUT_DATA_O),
	.OUT_VALID_O(OUT_VALID_O), .OUT_LAST_O(OUT_LAST_O), .OUT_KIND_O(OUT_KIND_O), .OUT_READY_I(OUT_READY_I));

// ==== sim/interleaved_parity_fec_tb_top.sv ====
// Self-checking bench for the parity repair block.
`timescale 1ns/1ps
`include "fec_defs.vh"

module interleaved_parity_fec_tb_top;
	typedef logic [7:0] bq_t[$];
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] st_d [0:1] = '{8'h00, 8'h00};
	logic [1:0] st_v = 2'h0;
	logic [1:0] st_l = 2'h0;
	wire [1:0] st_r;
	wire [1:0] bresp;
	wire [1:0] rresp;
	wire [31:0] rdata;
	wire [7:0] od;
	wire bvalid, rvalid, awready, wready, arready, ov, ol, ok, orr;
	int failures = 0;
	int checks_done = 0;
	bq_t cap, pa, pb, pr;
	logic cap_k;
	logic [31:0] rd;
	logic [1:0] rs;
	row_t rows [0:9] = '{'{`FEC_REG_CTRL, 0, 0}, '{`FEC_REG_GEOM, `FEC_GEOM_RST, 0}, '{`FEC_REG_BASE, 0, 0},
		'{`FEC_REG_RHDR, 32'h60, 0}, '{`FEC_REG_RTS, 0, 0}, '{`FEC_REG_RSSRC, 0, 0}, '{`FEC_REG_WIN, `FEC_WIN_RST, 0},
		'{`FEC_REG_STAT, 0, 0}, '{`FEC_REG_MISS, 0, 0}, '{8'h24, 0, `FEC_RESP_SLVERR}};

	fec_parity_core fec_parity_core_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
		.BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.SRC_DATA_I(st_d[0]), .SRC_VALID_I(st_v[0]), .SRC_LAST_I(st_l[0]), .SRC_READY_O(st_r[0]),
		.REP_DATA_I(st_d[1]), .REP_VALID_I(st_v[1]), .REP_LAST_I(st_l[1]), .REP_READY_O(st_r[1]),
		.OUT_DATA_O(od), .OUT_VALID_O(ov), .OUT_LAST_O(ol), .OUT_KIND_O(ok), .OUT_READY_I(orr));
	fec_out_sink fec_out_sink_i (.clk_i(clk), .rst_n_i(rst_n), .out_ready_o(orr));

	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (ov && orr) begin
			cap.push_back(od);
			cap_k = ok;
		end
	end

	task close_out;
		begin
			$display("checks %0d mismatches %0d", checks_done, failures);
			if (failures == 0 && checks_done > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks_done++;
			if (got !== exp) begin
				failures++;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task timeout;
		begin
			failures++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			close_out();
		end
	endtask
	// One register access; the handshake rules are the same for both directions.
	task axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ah, wh, bh;
		begin
			@(posedge clk);
			if (wr) begin
				awaddr <= a;
				wdata <= d;
				awvalid <= 1'b1;
				wvalid <= 1'b1;
				bready <= 1'b1;
			end else begin
				araddr <= a;
				arvalid <= 1'b1;
				rready <= 1'b1;
			end
			n = 0;
			bh = 1'b0;
			while (!bh) begin
				@(negedge clk);
				ah = wr ? (awvalid && awready) : (arvalid && arready);
				wh = wvalid && wready;
				bh = wr ? (bvalid === 1'b1) : (rvalid === 1'b1);
				rs = wr ? bresp : rresp;
				rd = rdata;
				@(posedge clk);
				if (ah) begin
					awvalid <= 1'b0;
					arvalid <= 1'b0;
				end
				if (wh) wvalid <= 1'b0;
				if (bh) begin
					bready <= 1'b0;
					rready <= 1'b0;
				end
				n++;
				if (n > 100) timeout();
			end
		end
	endtask
	task send(input int k, input bq_t p);
		int n;
		logic hit;
		begin
			@(posedge clk);
			foreach (p[i]) begin
				st_d[k] <= p[i];
				st_v[k] <= 1'b1;
				st_l[k] <= (i == p.size() - 1);
				n = 0;
				hit = 1'b0;
				while (!hit) begin
					@(negedge clk);
					hit = (st_r[k] === 1'b1);
					@(posedge clk);
					n++;
					if (n > 300) timeout();
				end
			end
			st_v[k] <= 1'b0;
			st_d[k] <= ~p[p.size() - 1];
		end
	endtask
	task poll(input logic [31:0] m, input logic [31:0] v);
		int n;
		begin
			n = 0;
			rd = 32'h0;
			while ((rd & m) !== v) begin
				axi(0, `FEC_REG_STAT, 0);
				n++;
				if (n > 400) timeout();
			end
		end
	endtask
	task wait_cap(input int n);
		int k;
		begin
			k = 0;
			while (cap.size() < n) begin
				@(posedge clk);
				k++;
				if (k > 2000) timeout();
			end
			repeat (20) @(posedge clk);
			check(cap.size(), n);
		end
	endtask
	function automatic bq_t mk_src(logic [7:0] b0, logic [7:0] b1, logic [15:0] sq, logic [31:0] ts, int n);
		bq_t p;
		p = {b0, b1, sq[15:8], sq[7:0], ts[31:24], ts[23:16], ts[15:8], ts[7:0], 8'h5A, 8'hC3, 8'h11, 8'hE7};
		for (int j = 0; j < n; j++) p.push_back(8'(j * 37 + sq));
		return p;
	endfunction
	// Folds one source string into the repair image; short strings act as zero padded.
	function automatic bq_t fold(bq_t r, bq_t s);
		logic [15:0] ln;
		ln = 16'(s.size() - 12);
		r[0] ^= s[0] & 8'h3F;
		r[1] ^= s[1] & 8'h80;
		r[16] ^= s[1] & 8'h7F;
		r[14] ^= ln[15:8];
		r[15] ^= ln[7:0];
		for (int j = 0; j < 4; j++) r[20 + j] ^= s[4 + j];
		for (int j = 12; j < s.size(); j++) r[16 + j] ^= s[j];
		return r;
	endfunction
	function automatic bq_t mk_rep(bq_t s0, bq_t s1, logic [7:0] l, logic [7:0] d, logic [15:0] b);
		bq_t r;
		logic [95:0] h;
		h = 96'h8055_1234_AABB_CCDD_1122_3344;
		for (int j = 0; j < 16 + ((s0.size() > s1.size()) ? s0.size() : s1.size()); j++) r.push_back(8'h00);
		for (int j = 0; j < 12; j++) r[j] = h[95 - 8 * j -: 8];
		r[12] = b[15:8];
		r[13] = b[7:0];
		r[16] = 8'h80;
		r[25] = l;
		r[26] = d;
		return fold(fold(r, s0), s1);
	endfunction

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			axi(0, rows[i].a, 0);
			check(rd, rows[i].d);
			check(rs, rows[i].r);
		end
		$display("reset values done");
		axi(1, `FEC_REG_GEOM, 32'h0000_0100);
		axi(1, `FEC_REG_CTRL, 32'h2);
		axi(0, `FEC_REG_STAT, 0);
		check(rd[7:0], 8'h80);
		axi(1, 8'h24, 32'h0);
		check(rs, `FEC_RESP_SLVERR);
		$display("zero columns done");
		axi(1, `FEC_REG_RHDR, 32'h1234_0055);
		axi(1, `FEC_REG_RTS, 32'hAABB_CCDD);
		axi(1, `FEC_REG_RSSRC, 32'h1122_3344);
		axi(1, `FEC_REG_GEOM, 32'h0000_0203);
		axi(1, `FEC_REG_BASE, 32'h0000_FFFE);
		axi(1, `FEC_REG_CTRL, 32'h2);
		pa = mk_src(8'hA0, 8'h9F, 16'h0001, 32'h0102_0304, 8);
		pb = mk_src(8'h81, 8'h21, 16'hFFFE, 32'hF0E0_D0C0, 5);
		send(0, pa);
		send(0, mk_src(8'h80, 8'h00, 16'hFFFF, 32'h0, 3));
		send(0, pb);
		pr = mk_rep(pa, pb, 8'h03, 8'h02, 16'hFFFE);
		wait_cap(pr.size());
		check(cap_k, 1'b0);
		foreach (pr[i]) check(cap[i], pr[i]);
		check(cap[0], 8'hA1);
		check({cap[16], cap[20]}, 16'hBEF1);
		check({cap[14], cap[15]}, 16'h000D);
		check({cap[12], cap[13]}, 16'hFFFE);
		check({cap[25], cap[26]}, 16'h0302);
		$display("encode done");
		cap = {};
		pa = mk_src(8'hA3, 8'h1E, 16'd20, 32'h1111_2222, 9);
		pb = mk_src(8'h91, 8'hE2, 16'd21, 32'h3333_4444, 4);
		pr = mk_rep(pa, pb, 8'h01, 8'h02, 16'd20);
		axi(1, `FEC_REG_GEOM, 32'h0000_0201);
		axi(1, `FEC_REG_BASE, 32'd20);
		axi(1, `FEC_REG_CTRL, 32'h3);
		send(1, pr);
		send(0, pa);
		wait_cap(pb.size());
		check(cap_k, 1'b1);
		foreach (pb[i]) check(cap[i], pb[i]);
		poll(32'h10, 32'h10);
		axi(0, `FEC_REG_MISS, 0);
		check(rd, 32'h0014_0015);
		$display("rebuild done");
		cap = {};
		axi(1, `FEC_REG_CTRL, 32'h3);
		send(0, pa);
		send(0, pb);
		poll(32'h7, 32'h5);
		check(rd[4], 1'b0);
		check(st_r[1], 1'b0);
		check(cap.size(), 0);
		$display("no loss done");
		axi(1, `FEC_REG_WIN, 32'h1);
		axi(1, `FEC_REG_CTRL, 32'h3);
		send(1, pr);
		poll(32'h20, 32'h20);
		check(cap.size(), 0);
		$display("window expiry done");
		axi(1, `FEC_REG_CTRL, 32'h3);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		axi(0, `FEC_REG_STAT, 0);
		check(rd, 32'h0);
		axi(0, `FEC_REG_GEOM, 0);
		check(rd, `FEC_GEOM_RST);
		$display("mid-run reset done");
		close_out();
	end
endmodule
